//--- hw/acw_top.sv
// Function
// - the two-bit hardware trigger select picks timer, event link, calendar clock or interval timer.
// - the positive reference select picks supply, external pin or internal 1.45 V; 11 is prohibited.
// - the negative reference bit ties low reference to ground at 0 and to the external pin at 1.
// - range-check 0 raises the end interrupt only when lower <= result <= upper.
// - range-check 1 raises the end interrupt only when result < lower or result > upper.
// - the low-power wait bit enables standby-triggered conversion when 1.
// - the resolution bit gives 10-bit results at 0 and 8-bit results at 1.
// - separate writable 8-bit upper and lower limit registers bound each result.
// - the channel code decodes to inputs 0-3, 16-22, amplifier output, temp sensor, vref.
// - the request flag reads 1 while pending; the mask blocks servicing at 1.
// - the conversion mode bit gives repeated conversion at 0 and one-shot at 1.
// - trigger mode upper bit 0 is software, 10 hardware no-wait, 11 hardware with wait.
//
// Implementation choices: the address map and the AXI4-Lite register port.
module acw_top (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        timer_channel_interrupt_in,
  input  wire logic        event_link_block_in,
  input  wire logic        calendar_clock_interrupt_in,
  input  wire logic        interval_timer_interrupt_in,
  input  wire logic        standby_conversion_mode_in,
  input  wire logic [9:0]  conversion_result_in,
  output logic [1:0]       pos_reference_sel_out,
  output logic             neg_reference_sel_out,
  output logic [4:0]       analog_input_index_out,
  output logic [1:0]       analog_input_kind_out,
  output logic             conversion_start_out,
  output logic             resolution_8bit_out,
  output logic             irq_out
);
  // ==========================================================================
  // input synchronisers (triggers come from other blocks' pins or domains)
  logic [3:0] trig_s1_q, trig_s2_q, trig_s3_q;
  logic       sby_s1_q, sby_s2_q;
  logic [3:0] trig_s1_d;

  always_comb begin
    trig_s1_d = {interval_timer_interrupt_in, calendar_clock_interrupt_in,
                 event_link_block_in, timer_channel_interrupt_in};
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      trig_s1_q <= 4'h0;
      trig_s2_q <= 4'h0;
      trig_s3_q <= 4'h0;
      sby_s1_q  <= 1'b0;
      sby_s2_q  <= 1'b0;
    end else begin
      trig_s1_q <= trig_s1_d;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      sby_s1_q  <= standby_conversion_mode_in;
      sby_s2_q  <= sby_s1_q;
    end
  end

  // ==========================================================================
  // register file and axi4-lite slave
  logic [7:0]  mode1_q, mode2_q, upper_q, lower_q, chsel_q, mask_q;
  logic [7:0]  mode1_d, mode2_d, upper_d, lower_d, chsel_d, mask_d;
  logic [7:0]  awaddr_q, awaddr_d, wbyte_q, wbyte_d;
  logic        flag_q, flag_d, wstrb0_q, wstrb0_d;
  logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic        aw_hold_d, w_hold_d, bvalid_d, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        soft_start_q, soft_start_d;
  logic        wr_fire, event_set, ar_take, illegal_cfg;
  logic [9:0]  result_q;
  logic        busy_q;

  always_comb begin
    wr_fire      = aw_hold_q && w_hold_q && !bvalid_q;
    ar_take      = s_axi_arvalid_in && !rvalid_q;
    aw_hold_d    = aw_hold_q;
    w_hold_d     = w_hold_q;
    awaddr_d     = awaddr_q;
    wbyte_d      = wbyte_q;
    wstrb0_d     = wstrb0_q;
    bvalid_d     = bvalid_q;
    bresp_d      = bresp_q;
    rvalid_d     = rvalid_q;
    rresp_d      = rresp_q;
    rdata_d      = rdata_q;
    mode1_d      = mode1_q;
    mode2_d      = mode2_q;
    upper_d      = upper_q;
    lower_d      = lower_q;
    chsel_d      = chsel_q;
    mask_d       = mask_q;
    flag_d       = flag_q;
    soft_start_d = 1'b0;
    if (s_axi_awvalid_in && !aw_hold_q) begin
      aw_hold_d = 1'b1;
      awaddr_d  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !w_hold_q) begin
      w_hold_d = 1'b1;
      wbyte_d  = s_axi_wdata_in[7:0];
      wstrb0_d = s_axi_wstrb_in[0];
    end
    if (wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = 2'b00;
      if (wstrb0_q) begin
        unique case ({awaddr_q[7:2], 2'b00})
          acw_pkg::OFS_MODE1: begin
            mode1_d = wbyte_q & acw_pkg::MASK_MODE1;
            // writing with trigger mode upper bit 0 starts a software conversion
            soft_start_d = !wbyte_q[acw_pkg::TRIG_MODE_HI];
          end
          acw_pkg::OFS_MODE2:    mode2_d = wbyte_q & acw_pkg::MASK_MODE2;
          acw_pkg::OFS_UPPER:    upper_d = wbyte_q;
          acw_pkg::OFS_LOWER:    lower_d = wbyte_q;
          acw_pkg::OFS_CHSEL:    chsel_d = wbyte_q & acw_pkg::MASK_CHSEL;
          acw_pkg::OFS_IRQ_FLAG: flag_d  = flag_q & ~wbyte_q[0];
          acw_pkg::OFS_IRQ_MASK: mask_d  = {7'h00, wbyte_q[0]};
          acw_pkg::OFS_RESULT, acw_pkg::OFS_STATUS: ;
          default:               bresp_d = 2'b10;
        endcase
      end
    end
    if (bvalid_q && s_axi_bready_in) begin
      bvalid_d = 1'b0;
    end
    // a hardware set wins over a same-cycle software clear
    if (event_set) begin
      flag_d = 1'b1;
    end
    if (rvalid_q && s_axi_rready_in) begin
      rvalid_d = 1'b0;
    end
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d  = 2'b00;
      unique case ({s_axi_araddr_in[7:2], 2'b00})
        acw_pkg::OFS_MODE1:    rdata_d = {24'h0, mode1_q};
        acw_pkg::OFS_MODE2:    rdata_d = {24'h0, mode2_q};
        acw_pkg::OFS_UPPER:    rdata_d = {24'h0, upper_q};
        acw_pkg::OFS_LOWER:    rdata_d = {24'h0, lower_q};
        acw_pkg::OFS_CHSEL:    rdata_d = {24'h0, chsel_q};
        acw_pkg::OFS_IRQ_FLAG: rdata_d = {31'h0, flag_q};
        acw_pkg::OFS_IRQ_MASK: rdata_d = {24'h0, mask_q};
        acw_pkg::OFS_RESULT:   rdata_d = {22'h0, result_q};
        acw_pkg::OFS_STATUS:   rdata_d = {30'h0, illegal_cfg, busy_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = 2'b10;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wbyte_q      <= 8'h00;
      wstrb0_q     <= 1'b0;
      bvalid_q     <= 1'b0;
      bresp_q      <= 2'b00;
      rvalid_q     <= 1'b0;
      rresp_q      <= 2'b00;
      rdata_q      <= 32'h0;
      mode1_q      <= acw_pkg::RST_MODE1;
      mode2_q      <= acw_pkg::RST_MODE2;
      upper_q      <= acw_pkg::RST_UPPER;
      lower_q      <= acw_pkg::RST_LOWER;
      chsel_q      <= acw_pkg::RST_CHSEL;
      mask_q       <= acw_pkg::RST_IRQ_MASK;
      flag_q       <= 1'b0;
      soft_start_q <= 1'b0;
    end else begin
      aw_hold_q    <= aw_hold_d;
      w_hold_q     <= w_hold_d;
      awaddr_q     <= awaddr_d;
      wbyte_q      <= wbyte_d;
      wstrb0_q     <= wstrb0_d;
      bvalid_q     <= bvalid_d;
      bresp_q      <= bresp_d;
      rvalid_q     <= rvalid_d;
      rresp_q      <= rresp_d;
      rdata_q      <= rdata_d;
      mode1_q      <= mode1_d;
      mode2_q      <= mode2_d;
      upper_q      <= upper_d;
      lower_q      <= lower_d;
      chsel_q      <= chsel_d;
      mask_q       <= mask_d;
      flag_q       <= flag_d;
      soft_start_q <= soft_start_d;
    end
  end

  // ==========================================================================
  // configuration decode
  logic       hw_trig_edge, trig_hw, trig_wait, one_shot, lp_wait;
  logic [1:0] hw_trigger_select, pos_reference_select, ain_kind;
  logic [4:0] ch_code, ain_idx;
  logic [3:0] trig_rise;

  always_comb begin
    hw_trigger_select    = mode1_q[acw_pkg::TRIG_SEL_LO +: 2];
    trig_hw              = mode1_q[acw_pkg::TRIG_MODE_HI];
    trig_wait            = mode1_q[acw_pkg::TRIG_MODE_LO];
    one_shot             = mode1_q[acw_pkg::CONV_MODE];
    pos_reference_select = mode2_q[acw_pkg::POS_REF_LO +: 2];
    lp_wait              = mode2_q[acw_pkg::LP_WAIT];
    ch_code              = chsel_q[4:0];
    trig_rise            = trig_s2_q & ~trig_s3_q;
    unique case (acw_pkg::acw_trig_src_e'(hw_trigger_select))
      acw_pkg::ACW_TRIG_TIMER:    hw_trig_edge = trig_rise[0];
      acw_pkg::ACW_TRIG_EVENT:    hw_trig_edge = trig_rise[1];
      acw_pkg::ACW_TRIG_CALENDAR: hw_trig_edge = trig_rise[2];
      acw_pkg::ACW_TRIG_INTERVAL: hw_trig_edge = trig_rise[3];
    endcase
    // kind: 0 external pin, 1 amplifier, 2 temperature, 3 internal vref
    ain_idx  = ch_code;
    ain_kind = 2'd0;
    illegal_cfg = (pos_reference_select == 2'b11);
    if (chsel_q[acw_pkg::INT_SRC]) begin
      ain_kind = (ch_code == acw_pkg::CH_TEMP) ? 2'd2 : 2'd3;
      if (ch_code != acw_pkg::CH_TEMP && ch_code != acw_pkg::CH_VREF) begin
        illegal_cfg = 1'b1;
      end
    end else if (ch_code == acw_pkg::CH_AMP_OUT) begin
      ain_kind = 2'd1;
    end else if (ch_code[4] ? (ch_code > 5'h16) : (ch_code > 5'h03)) begin
      illegal_cfg = 1'b1;
    end
  end

  // ==========================================================================
  // conversion sequencer and window compare
  typedef enum {ST_IDLE, ST_WAIT, ST_CONV} acw_state_e;
  acw_state_e state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic       busy_d, start_q, start_d, armed_q, armed_d;
  logic       go, trig_ok, in_win;
  logic [9:0] result_d, res_v, lo_v, hi_v;

  always_comb begin
    // the limits compare against the top eight result bits
    res_v    = mode2_q[acw_pkg::RES_SEL] ? {2'b00, conversion_result_in[9:2]}
                                          : conversion_result_in;
    lo_v     = mode2_q[acw_pkg::RES_SEL] ? {2'b00, lower_q} : {lower_q, 2'b00};
    hi_v     = mode2_q[acw_pkg::RES_SEL] ? {2'b00, upper_q} : {upper_q, 2'b11};
    in_win   = (lo_v <= res_v) && (res_v <= hi_v);
    // standby conversions only run when the low-power wait is enabled
    trig_ok  = hw_trig_edge && (!sby_s2_q || lp_wait);
    go       = trig_hw ? trig_ok : soft_start_q;
    state_d  = state_q;
    cnt_d    = cnt_q;
    result_d = result_q;
    start_d  = 1'b0;
    armed_d  = armed_q;
    event_set = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (go) begin
          // wait mode arms on first trigger, converts on the next one
          if (trig_hw && trig_wait && !armed_q) begin
            armed_d = 1'b1;
          end else begin
            state_d = ST_CONV;
            start_d = 1'b1;
            cnt_d   = 8'(acw_pkg::CONV_CYCLES);
          end
        end
      end
      ST_WAIT: begin
        if (go) begin
          state_d = ST_CONV;
          start_d = 1'b1;
          cnt_d   = 8'(acw_pkg::CONV_CYCLES);
        end
      end
      ST_CONV: begin
        if (cnt_q > 8'h01) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          result_d  = res_v;
          event_set = mode2_q[acw_pkg::RANGE_POL] ? !in_win : in_win;
          armed_d   = 1'b0;
          // repeated mode keeps converting without a new trigger
          if (one_shot) begin
            state_d = trig_hw ? ST_WAIT : ST_IDLE;
          end else begin
            start_d = 1'b1;
            cnt_d   = 8'(acw_pkg::CONV_CYCLES);
          end
        end
      end
    endcase
    busy_d = (state_d == ST_CONV);
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 8'h00;
      result_q <= 10'h000;
      busy_q   <= 1'b0;
      start_q  <= 1'b0;
      armed_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      result_q <= result_d;
      busy_q   <= busy_d;
      start_q  <= start_d;
      armed_q  <= armed_d;
    end
  end

  // ==========================================================================
  // registered outputs
  logic [1:0] posref_q, kind_q;
  logic [4:0] idx_q;
  logic       negref_q, res8_q, irq_q;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      posref_q <= 2'b00;
      negref_q <= 1'b0;
      idx_q    <= 5'h00;
      kind_q   <= 2'b00;
      res8_q   <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      posref_q <= pos_reference_select;
      negref_q <= mode2_q[acw_pkg::NEG_REF];
      idx_q    <= ain_idx;
      kind_q   <= ain_kind;
      res8_q   <= mode2_q[acw_pkg::RES_SEL];
      irq_q    <= flag_d & ~mask_d[0];
    end
  end

  assign s_axi_awready_out      = !aw_hold_q;
  assign s_axi_wready_out       = !w_hold_q;
  assign s_axi_bvalid_out       = bvalid_q;
  assign s_axi_bresp_out        = bresp_q;
  assign s_axi_arready_out      = !rvalid_q;
  assign s_axi_rvalid_out       = rvalid_q;
  assign s_axi_rresp_out        = rresp_q;
  assign s_axi_rdata_out        = rdata_q;
  assign pos_reference_sel_out  = posref_q;
  assign neg_reference_sel_out  = negref_q;
  assign analog_input_index_out = idx_q;
  assign analog_input_kind_out  = kind_q;
  assign conversion_start_out   = start_q;
  assign resolution_8bit_out    = res8_q;
  assign irq_out                = irq_q;
endmodule // acw_top

//--- pkg/acw_pkg.sv
package acw_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_MODE1    = 8'h00;
  localparam logic [7:0] OFS_MODE2    = 8'h04;
  localparam logic [7:0] OFS_UPPER    = 8'h08;
  localparam logic [7:0] OFS_LOWER    = 8'h0c;
  localparam logic [7:0] OFS_CHSEL    = 8'h10;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_RESULT   = 8'h1c;
  localparam logic [7:0] OFS_STATUS   = 8'h20;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_MODE1    = 8'h00;
  localparam logic [7:0] RST_MODE2    = 8'h00;
  localparam logic [7:0] RST_UPPER    = 8'hff;
  localparam logic [7:0] RST_LOWER    = 8'h00;
  localparam logic [7:0] RST_CHSEL    = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h01;

  // ==========================================================================
  // field positions and write masks
  localparam int TRIG_SEL_LO  = 0;
  localparam int CONV_MODE    = 5;
  localparam int TRIG_MODE_LO = 6;
  localparam int TRIG_MODE_HI = 7;
  localparam int RES_SEL      = 0;
  localparam int LP_WAIT      = 2;
  localparam int RANGE_POL    = 3;
  localparam int NEG_REF      = 5;
  localparam int POS_REF_LO   = 6;
  localparam int INT_SRC      = 7;
  localparam logic [7:0] MASK_MODE1 = 8'he3;
  localparam logic [7:0] MASK_MODE2 = 8'hed;
  localparam logic [7:0] MASK_CHSEL = 8'h9f;

  // ==========================================================================
  // status bits
  localparam int ST_BUSY      = 0;
  localparam int ST_ILLEGAL   = 1;

  // ==========================================================================
  // analog input routing
  localparam logic [4:0] CH_AMP_OUT = 5'h17;
  localparam logic [4:0] CH_TEMP    = 5'h00;
  localparam logic [4:0] CH_VREF    = 5'h01;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ        = 250;
  localparam int CONV_TIME_NS   = 200;
  localparam int CONV_CYCLES    = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    ACW_TRIG_TIMER,
    ACW_TRIG_EVENT,
    ACW_TRIG_CALENDAR,
    ACW_TRIG_INTERVAL
  } acw_trig_src_e;
endpackage

//--- test/acw_top_properties.sv
// ====
// protocol and output checks at the converter control ports
module acw_top_properties (
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [1:0]  pos_reference_sel_out,
  input wire logic        neg_reference_sel_out,
  input wire logic [4:0]  analog_input_index_out,
  input wire logic [1:0]  analog_input_kind_out,
  input wire logic        conversion_start_out,
  input wire logic        resolution_8bit_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |=> !irq_out &&
    !conversion_start_out && pos_reference_sel_out == 2'h0 && !resolution_8bit_out)
    else $error("outputs not idle after reset");
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data late");
  a_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  a_read_retires: assert property (s_axi_rvalid_out && s_axi_rready_in |=>
    !s_axi_rvalid_out) else $error("read data not retired");
  a_amp_route: assert property (analog_input_kind_out == 2'h1 |->
    analog_input_index_out == acw_pkg::CH_AMP_OUT) else $error("amplifier code wrong");
  a_int_route: assert property (analog_input_kind_out == 2'h2 |->
    analog_input_index_out == acw_pkg::CH_TEMP) else $error("temperature code wrong");
  a_pin_route: assert property (analog_input_index_out == acw_pkg::CH_AMP_OUT |->
    analog_input_kind_out != 2'h0) else $error("amplifier code routed to a pin");
  a_start_single: assert property (conversion_start_out |=> !conversion_start_out [*8])
    else $error("start pulse repeated inside conversion");
  a_cfg_by_write: assert property (!$stable({pos_reference_sel_out, neg_reference_sel_out,
    resolution_8bit_out}) |-> s_axi_bvalid_out || $past(s_axi_bvalid_out))
    else $error("reference or resolution moved without a write");

  c_start: cover property (conversion_start_out);
  c_irq: cover property ($rose(irq_out));
  c_slverr: cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
endmodule // acw_top_properties

bind acw_top acw_top_properties u_props (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in), .pos_reference_sel_out(pos_reference_sel_out),
  .neg_reference_sel_out(neg_reference_sel_out), .analog_input_index_out(analog_input_index_out),
  .analog_input_kind_out(analog_input_kind_out), .conversion_start_out(conversion_start_out),
  .resolution_8bit_out(resolution_8bit_out), .irq_out(irq_out));

//--- test/acw_src_model.sv
// ====
// trigger sources and analog front end seen by the converter
module acw_src_model (
  input  wire logic       clk_in,
  input  wire logic [1:0] src_in,
  input  wire logic       fire_in,
  input  wire logic [3:0] len_in,
  input  wire logic       standby_req_in,
  input  wire logic [9:0] value_in,
  output logic [3:0]      trig_out,
  output logic            standby_out,
  output logic [9:0]      result_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  logic [1:0] sel_q = 2'h0;
  // variable pulse length shows both quick and lingering interrupt lines
  always_ff @(posedge clk_in) begin
    if (fire_in) begin
      cnt_q <= len_in;
      sel_q <= src_in;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign trig_out    = (cnt_q != 4'h0) ? (4'h1 << sel_q) : 4'h0;
  assign standby_out = standby_req_in;
  assign result_out  = value_in;
endmodule // acw_src_model

//--- test/acw_top_tb.sv
module acw_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, fire, stby;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rv, seed;
  logic [3:0]  wstrb, flen;
  logic [1:0]  src, rp;
  logic [9:0]  res;
  logic        got, e;
  wire logic   awready, wready, bvalid, arready, rvalid, negref, start, r8, irq, sb;
  wire logic [1:0]  bresp, rresp, posref, kind;
  wire logic [31:0] rdata;
  wire logic [4:0]  idx;
  wire logic [3:0]  trg;
  wire logic [9:0]  resw;
  int n_errors, num_checks, cyc, ns;

  acw_top dut (.core_clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .timer_channel_interrupt_in(trg[0]),
    .event_link_block_in(trg[1]), .calendar_clock_interrupt_in(trg[2]),
    .interval_timer_interrupt_in(trg[3]), .standby_conversion_mode_in(sb),
    .conversion_result_in(resw), .pos_reference_sel_out(posref),
    .neg_reference_sel_out(negref), .analog_input_index_out(idx),
    .analog_input_kind_out(kind), .conversion_start_out(start),
    .resolution_8bit_out(r8), .irq_out(irq));
  acw_src_model u_src (.clk_in(clk), .src_in(src), .fire_in(fire), .len_in(flen),
    .standby_req_in(stby), .value_in(res), .trig_out(trg), .standby_out(sb), .result_out(resw));

  // ====
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic win(logic [9:0] r, logic [7:0] ul, logic [7:0] ll, logic pol, logic b8);
    logic [9:0] lo, hi;
    lo = b8 ? {2'h0, ll} : {ll, 2'h0};
    hi = b8 ? {2'h0, ul} : {ul, 2'h3};
    if (b8) r = {2'h0, r[9:2]};
    return pol ^ ((lo <= r) && (r <= hi));
  endfunction
  // {legal, kind} of a channel code, bit 5 is the internal source select
  function automatic logic [2:0] chx(logic [5:0] c);
    if (c[5]) return (c[4:0] < 5'h2) ? {1'b1, 1'b1, c[0]} : 3'h0;
    if (c[4:0] < 5'h4 || (c[4:0] >= 5'h10 && c[4:0] <= 5'h16)) return 3'h4;
    return (c[4:0] == 5'h17) ? 3'h5 : 3'h0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] gt);
    num_checks++;
    if (gt !== ex) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, ex, gt);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk);
    awaddr <= a; wdata <= {xs() & 32'hffffff00} | d; wstrb <= s;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!ad || !wd) begin
      @(posedge clk);
      if (!ad && awready) begin ad = 1; awvalid <= 0; end
      if (!wd && wready) begin wd = 1; wvalid <= 0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rp = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rv = rdata; rp = rresp;
    rready <= 0;
  endtask
  task automatic shoot(input logic [1:0] s, output logic g);
    src <= s; flen <= 4'h2 + 4'(xs() % 8); fire <= 1;
    @(posedge clk);
    fire <= 0;
    g = 0;
    repeat (14) begin @(posedge clk); if (start === 1'b1) g = 1; end
    if (g) repeat (acw_pkg::CONV_CYCLES + 4) @(posedge clk);
  endtask

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin n_errors++; end_sim(); end
  end

  // ====
  // main sequence
  initial begin
    logic [7:0] ul, ll;
    logic [2:0] cx;
    logic pol, b8, mk;
    rst_n = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; fire = 0;
    stby = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; src = 0; flen = 0; res = 0;
    seed = 32'h287727ce;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    rd(acw_pkg::OFS_MODE2); chk("mode2 rst", 0, rv);
    rd(acw_pkg::OFS_UPPER); chk("upper rst", 32'hff, rv);
    rd(acw_pkg::OFS_LOWER); chk("lower rst", 0, rv);
    rd(acw_pkg::OFS_CHSEL); chk("chsel rst", 0, rv);
    rd(acw_pkg::OFS_IRQ_MASK); chk("mask rst", 1, rv);
    rd(8'h24); chk("unmapped rd", 32'h2, {rv[29:0], rp});
    wr(8'h24, 8'h5a); chk("unmapped wr", 2, rp);
    wr(acw_pkg::OFS_UPPER, 8'h12, 4'he); rd(acw_pkg::OFS_UPPER); chk("strb off", 32'hff, rv);
    wr(acw_pkg::OFS_MODE2, 8'hff); rd(acw_pkg::OFS_MODE2); chk("mode2 bits", 32'hed, rv);
    chk("refs out", 4'hf, {posref, negref, r8});
    rd(acw_pkg::OFS_STATUS); chk("posref bad", 1, rv[1]);
    wr(acw_pkg::OFS_CHSEL, 8'hff); rd(acw_pkg::OFS_CHSEL); chk("chsel bits", 32'h9f, rv);
    wr(acw_pkg::OFS_MODE2, 8'h60); @(posedge clk);
    chk("refs out", 4'h6, {posref, negref, r8});
    wr(acw_pkg::OFS_MODE2, 8'h00);
    // temperature sensor code is reached with the core taken to be in high-speed main mode
    for (int c = 0; c < 64; c++) begin
      cx = chx(6'(c));
      wr(acw_pkg::OFS_CHSEL, {c[5], 2'h0, c[4:0]});
      rd(acw_pkg::OFS_STATUS); chk("illegal chan", !cx[2], rv[1]);
      if (cx[2]) chk("chan route", {cx[1:0], 5'(c)}, {kind, idx});
    end
    wr(acw_pkg::OFS_CHSEL, 8'h00);
    // window compare, boundary results in three of every four rounds
    for (int i = 0; i < 16; i++) begin
      ul = 8'(xs()); ll = 8'(xs()); pol = 1'(xs()); b8 = 1'(xs()); mk = (i % 5 == 4);
      case (i % 4)
        1: res <= {ll, 2'h0};
        2: res <= {ul, 2'h3};
        3: res <= {ll, 2'h0} - 10'h1;
        default: res <= 10'(xs());
      endcase
      wr(acw_pkg::OFS_UPPER, ul); wr(acw_pkg::OFS_LOWER, ll);
      wr(acw_pkg::OFS_MODE2, {4'h0, pol, 2'h0, b8}); wr(acw_pkg::OFS_IRQ_MASK, {7'h0, mk});
      wr(acw_pkg::OFS_MODE1, 8'h20);
      repeat (acw_pkg::CONV_CYCLES + 4) @(posedge clk);
      e = win(res, ul, ll, pol, b8);
      rd(acw_pkg::OFS_IRQ_FLAG); chk("end flag", e, rv);
      rd(acw_pkg::OFS_RESULT); chk("result", b8 ? 32'(res[9:2]) : 32'(res), rv);
      chk("irq level", e & !mk, irq);
      wr(acw_pkg::OFS_IRQ_FLAG, 8'h01); rd(acw_pkg::OFS_IRQ_FLAG); chk("flag clr", 0, rv);
    end
    wr(acw_pkg::OFS_MODE2, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(acw_pkg::OFS_MODE1, {6'h28, 2'(s)});
      for (int k = 0; k < 4; k++) begin
        shoot(2'(k), got); chk("hw source", k == s, got);
      end
    end
    wr(acw_pkg::OFS_MODE1, 8'h00);
    repeat (3 * acw_pkg::CONV_CYCLES) begin @(posedge clk); ns += start; end
    chk("repeat starts", 3, ns);
    wr(acw_pkg::OFS_MODE1, 8'h20); repeat (acw_pkg::CONV_CYCLES + 4) @(posedge clk);
    wr(acw_pkg::OFS_MODE1, 8'he0);
    shoot(2'h0, got); chk("wait arm", 0, got);
    shoot(2'h0, got); chk("wait start", 1, got);
    wr(acw_pkg::OFS_MODE1, 8'ha0);
    stby <= 1;
    shoot(2'h0, got); chk("standby off", 0, got);
    wr(acw_pkg::OFS_MODE2, 8'h04);
    shoot(2'h0, got); chk("standby on", 1, got);
    stby <= 0;
    end_sim();
  end
endmodule // acw_top_tb
